// ==== rpbc_pkg.sv ====
// constants, types and register map for the reset pin and boot capture block
package rpbc_pkg;

	//////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int RPBC_CLK_PERIOD_NS  = 8;
	localparam int RPBC_BOOT_HOLD_NS   = 5000;
	// least time, so round up to whole cycles
	localparam int RPBC_BOOT_HOLD_CYC  = (RPBC_BOOT_HOLD_NS + RPBC_CLK_PERIOD_NS - 1) / RPBC_CLK_PERIOD_NS;
	localparam int RPBC_POR_DRIVE_CYC  = 16;
	localparam int RPBC_PH1_CYC        = 8;
	localparam int RPBC_PH2_CYC        = 8;
	localparam int RPBC_CNT_W          = 12;

	//////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [11:0] RPBC_OFF_FESS    = 12'h000;
	localparam logic [11:0] RPBC_OFF_STATUS  = 12'h004;
	localparam logic [11:0] RPBC_OFF_CAPT    = 12'h008;
	localparam int          RPBC_FESS_SHORT_BIT  = 0;
	localparam int          RPBC_FESS_EXTCLK_BIT = 1;
	localparam logic [1:0]  RPBC_FESS_RST        = 2'h0;
	localparam int          RPBC_STAT_STATE_LSB  = 0;
	localparam int          RPBC_STAT_MODE_LSB   = 8;
	localparam int          RPBC_STAT_STATIC_BIT = 10;
	localparam int          RPBC_STAT_SECT_LSB   = 16;
	localparam logic [1:0]  RPBC_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RPBC_RESP_SLVERR = 2'h2;

	//////////////////////////////////////////////////////////////////////////
	// boot selection
	localparam logic [1:0] RPBC_SEL_UART = 2'h0;
	localparam logic [1:0] RPBC_SEL_CAN  = 2'h1;

	typedef enum logic [1:0] {
		RPBC_BOOT_FLASH  = 2'h0,
		RPBC_BOOT_UART   = 2'h1,
		RPBC_BOOT_CAN    = 2'h2,
		RPBC_BOOT_STATIC = 2'h3
	} rpbc_boot_mode_t;

	// reset sequence phases, one-hot
	typedef enum logic [5:0] {
		RPBC_PHASE_A    = 6'h01,
		RPBC_FUNC_ONE   = 6'h02,
		RPBC_FUNC_TWO   = 6'h04,
		RPBC_FUNC_THREE = 6'h08,
		RPBC_BOOT_HOLD  = 6'h10,
		RPBC_RUN        = 6'h20
	} rpbc_state_t;

	// boot strap pins, synchronised or captured
	typedef struct packed {
		logic fab;
		logic sel_high;
		logic sel_low;
	} rpbc_boot_pins_t;

endpackage

// ==== rpbc_sync.sv ====
// two-flop level synchroniser for a group of pins
`timescale 1ns/10ps
module rpbc_sync
	import rpbc_pkg::*;
#(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clock,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			meta_reg <= RESET_VAL;
			sync_out <= RESET_VAL;
		end else begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end

endmodule // rpbc_sync

// ==== rpbc_top.sv ====
// reset pin sequencer, boot mode capture and pin state control with AXI4-Lite registers
//
// Behaviour
// - drive power-on pin low for the first 16 cycles of phase a
// - leave phase a only once pin reads high
// - external power-on pin low returns to phase a
// - drive functional reset pin from phase a
// - leave phase three only after pin released
// - external reset low re-enters phase one/three
// - reset pins open drain, pull low only
// - decode flash, serial or bus boot
// - boot lowest flash sector with valid signature
// - no valid signature means static mode
// - boot strap pins carry weak pull-downs
// - general pins and test output high impedance
// - external clock disables crystal output drive
// - debug enable low holds debug port reset
// - asserted event input forces debug mode only in run phase with debug enable high
`timescale 1ns/10ps
module rpbc_top
	import rpbc_pkg::*;
#(
	parameter int SECTORS = 4,
	parameter int SECT_W  = 2
) (
	input  wire logic               clock,
	input  wire logic               rst_b,
	// AXI4-Lite slave
	input  wire logic [11:0]        s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic [1:0]              s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [11:0]        s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic [31:0]             s_axi_rdata,
	output logic [1:0]              s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	// open-drain reset pins
	input  wire logic               power_on_reset_pin_n_in,
	output logic                    power_on_reset_pin_n_out,
	output logic                    power_on_reset_pin_n_oe,
	input  wire logic               functional_reset_pin_n_in,
	output logic                    functional_reset_pin_n_out,
	output logic                    functional_reset_pin_n_oe,
	output logic                    reset_pin_pull_down_en,
	// boot strap pins and flash signature status
	input  wire logic               force_alternate_boot_pin,
	input  wire logic               boot_selector_bit_high,
	input  wire logic               boot_selector_bit_low,
	output logic                    boot_pin_pull_down_en,
	input  wire logic [SECTORS-1:0] flash_sig_valid,
	output logic [1:0]              boot_mode,
	output logic [SECT_W-1:0]       boot_sector,
	output logic                    static_mode,
	output logic                    core_reset_n,
	// pad control
	output logic                    gpio_drive_allow,
	output logic                    test_data_out_oe,
	output logic                    test_in_pull_up_en,
	output logic                    crystal_output_drive_en,
	// debug port
	input  wire logic               debug_port_enable_pin,
	input  wire logic               debug_event_input_n,
	output logic                    debug_port_reset,
	output logic                    debug_force
);

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [1:0]      rst_pins_sync;
	rpbc_boot_pins_t boot_sync;
	logic            por_s, func_s;

	// reset pins settle low so a stale value never looks like a release
	rpbc_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_sync_rst (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in ({power_on_reset_pin_n_in, functional_reset_pin_n_in}),
		.sync_out (rst_pins_sync)
	);
	rpbc_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_sync_boot (
		.clock    (clock),
		.rst_b    (rst_b),
		.async_in ({force_alternate_boot_pin, boot_selector_bit_high, boot_selector_bit_low}),
		.sync_out (boot_sync)
	);
	assign por_s  = rst_pins_sync[1];
	assign func_s = rst_pins_sync[0];

	//////////////////////////////////////////////////////////////////////////
	// registers and state
	rpbc_state_t           state_reg, state_next;
	logic [RPBC_CNT_W-1:0] cnt_reg, cnt_next;
	logic [1:0]            fess_reg;
	rpbc_boot_pins_t       capt_reg;
	rpbc_boot_mode_t       mode_reg, mode_next;
	logic [SECT_W-1:0]     sect_reg;
	logic                  static_reg;

	logic                  short_sel, ext_clk_sel, por_done, in_run, func_ext_low, any_valid;
	logic [SECTORS:0]      found;
	logic [SECTORS-1:0]    pick;
	logic [SECT_W-1:0]     sect_next;
	logic [SECT_W-1:0]     sect_acc [SECTORS+1];
	logic [1:0]            sel_code;

	assign short_sel    = fess_reg[RPBC_FESS_SHORT_BIT];
	assign ext_clk_sel  = fess_reg[RPBC_FESS_EXTCLK_BIT];
	assign por_done     = (cnt_reg == RPBC_CNT_W'(RPBC_POR_DRIVE_CYC));
	assign in_run       = (state_reg == RPBC_RUN);
	// the device has let go of the pin here, so a low comes from outside
	assign func_ext_low = ((state_reg == RPBC_BOOT_HOLD) || in_run) && !func_s;

	//////////////////////////////////////////////////////////////////////////
	// lowest-numbered sector with a valid signature wins
	assign found[0]    = 1'b0;
	assign sect_acc[0] = '0;
	generate
		for (genvar i = 0; i < SECTORS; i++) begin : g_sect
			assign pick[i]       = flash_sig_valid[i] && !found[i];
			assign found[i+1]    = found[i] || flash_sig_valid[i];
			// at most one pick bit is set, so or-ing the indices gives the winner
			assign sect_acc[i+1] = sect_acc[i] | (pick[i] ? SECT_W'(i) : SECT_W'(0));
		end
	endgenerate
	assign any_valid = found[SECTORS];
	assign sect_next = sect_acc[SECTORS];

	// boot decode from the captured straps; unlisted selector codes have no loader, so stay quiet
	assign sel_code  = {capt_reg.sel_high, capt_reg.sel_low};
	assign mode_next = rpbc_boot_mode_t'(!capt_reg.fab ? (any_valid ? RPBC_BOOT_FLASH : RPBC_BOOT_STATIC)
		: (sel_code == RPBC_SEL_UART) ? RPBC_BOOT_UART : (sel_code == RPBC_SEL_CAN) ? RPBC_BOOT_CAN
		: RPBC_BOOT_STATIC);

	//////////////////////////////////////////////////////////////////////////
	// reset phase sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg + RPBC_CNT_W'(1);
		case (state_reg)
			RPBC_PHASE_A: begin
				if (por_done) begin
					cnt_next = cnt_reg;
					if (por_s) begin
						state_next = RPBC_FUNC_ONE;
						cnt_next   = '0;
					end
				end
			end
			RPBC_FUNC_ONE: begin
				if (cnt_reg == RPBC_CNT_W'(RPBC_PH1_CYC - 1)) begin
					state_next = RPBC_FUNC_TWO;
					cnt_next   = '0;
				end
			end
			RPBC_FUNC_TWO: begin
				if (cnt_reg == RPBC_CNT_W'(RPBC_PH2_CYC - 1)) begin
					state_next = RPBC_FUNC_THREE;
					cnt_next   = '0;
				end
			end
			RPBC_FUNC_THREE: begin
				cnt_next = '0;
				if (func_s) begin
					state_next = RPBC_BOOT_HOLD;
				end
			end
			RPBC_BOOT_HOLD: begin
				// straps are still held by the board for this window
				if (cnt_reg == RPBC_CNT_W'(RPBC_BOOT_HOLD_CYC - 1)) begin
					state_next = RPBC_RUN;
					cnt_next   = '0;
				end
			end
			RPBC_RUN: begin
				cnt_next = '0;
			end
			default: begin
				state_next = RPBC_PHASE_A;
				cnt_next   = '0;
			end
		endcase
		// external functional reset, short or long re-entry
		if (func_ext_low) begin
			state_next = short_sel ? RPBC_FUNC_THREE : RPBC_FUNC_ONE;
			cnt_next   = '0;
		end
		// external power-on reset overrides everything
		if ((state_reg != RPBC_PHASE_A) && !por_s) begin
			state_next = RPBC_PHASE_A;
			cnt_next   = '0;
		end
	end

	// sequencer and capture flops
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			state_reg  <= RPBC_PHASE_A;
			cnt_reg    <= '0;
			capt_reg   <= '0;
			mode_reg   <= RPBC_BOOT_FLASH;
			sect_reg   <= '0;
			static_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			if (state_reg != RPBC_RUN && state_next != RPBC_RUN) begin
				capt_reg <= boot_sync;
			end
			if (state_reg == RPBC_BOOT_HOLD && state_next == RPBC_RUN) begin
				mode_reg   <= mode_next;
				sect_reg   <= sect_next;
				static_reg <= (mode_next == RPBC_BOOT_STATIC);
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// pins: open drain, only ever pulled low
	assign power_on_reset_pin_n_out   = 1'b0;
	assign functional_reset_pin_n_out = 1'b0;
	assign power_on_reset_pin_n_oe    = (state_reg == RPBC_PHASE_A) && !por_done;
	// released in phase three so the board's release can be seen
	assign functional_reset_pin_n_oe  = (state_reg == RPBC_PHASE_A) || (state_reg == RPBC_FUNC_ONE)
		|| (state_reg == RPBC_FUNC_TWO);
	assign reset_pin_pull_down_en     = 1'b1;
	assign boot_pin_pull_down_en      = 1'b1;

	// pads stay high impedance until the run phase
	assign gpio_drive_allow        = in_run;
	assign test_data_out_oe        = in_run && debug_port_enable_pin;
	assign test_in_pull_up_en      = 1'b1;
	assign crystal_output_drive_en = in_run && !ext_clk_sel;
	assign debug_port_reset        = !debug_port_enable_pin;
	assign debug_force             = in_run && debug_port_enable_pin && !debug_event_input_n;

	assign boot_mode    = mode_reg;
	assign boot_sector  = sect_reg;
	assign static_mode  = static_reg;
	assign core_reset_n = in_run && !static_reg;

	//////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave
	logic        aw_got_reg, w_got_reg, wstrb0_reg, wr_go, wr_hit;
	logic        rd_fess, rd_stat, rd_capt;
	logic [11:0] awaddr_reg;
	logic [31:0] wdata_reg, rd_data, stat_word;

	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go         = aw_got_reg && w_got_reg && !s_axi_bvalid;
	assign wr_hit        = (awaddr_reg[11:2] == RPBC_OFF_FESS[11:2]);
	assign rd_fess       = (s_axi_araddr[11:2] == RPBC_OFF_FESS[11:2]);
	assign rd_stat       = (s_axi_araddr[11:2] == RPBC_OFF_STATUS[11:2]);
	assign rd_capt       = (s_axi_araddr[11:2] == RPBC_OFF_CAPT[11:2]);
	assign stat_word     = (32'(state_reg) << RPBC_STAT_STATE_LSB) | (32'(mode_reg) << RPBC_STAT_MODE_LSB)
		| (32'(static_reg) << RPBC_STAT_STATIC_BIT) | (32'(sect_reg) << RPBC_STAT_SECT_LSB);
	assign rd_data       = rd_fess ? 32'(fess_reg) : rd_stat ? stat_word : rd_capt ? 32'(capt_reg) : 32'h0;

	// write path: address and data in either order, response after both
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			awaddr_reg   <= '0;
			wdata_reg    <= '0;
			wstrb0_reg   <= 1'b0;
			fess_reg     <= RPBC_FESS_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RPBC_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg  <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb0_reg <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? RPBC_RESP_OKAY : RPBC_RESP_SLVERR;
				if (wr_hit && wstrb0_reg) begin
					fess_reg <= wdata_reg[1:0];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// read path: one cycle to data
	always_ff @(posedge clock) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RPBC_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_data;
			s_axi_rresp  <= (rd_fess || rd_stat || rd_capt) ? RPBC_RESP_OKAY : RPBC_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);

	AST_POR_DRIVE: assert property ((state_reg == RPBC_PHASE_A && cnt_reg == '0) |-> power_on_reset_pin_n_oe [*3])
		else $error("power-on pin not driven in phase a");
	AST_POR_WAIT: assert property ((state_reg == RPBC_PHASE_A && por_done && !por_s) |=> state_reg == RPBC_PHASE_A)
		else $error("left phase a before power-on pin release");
	AST_POR_REENTER: assert property ((state_reg != RPBC_PHASE_A && !por_s) |=> state_reg == RPBC_PHASE_A)
		else $error("external power-on reset ignored");
	AST_FUNC_DRIVE: assert property ($rose(state_reg == RPBC_FUNC_ONE) |-> functional_reset_pin_n_oe throughout
		(state_reg == RPBC_FUNC_ONE) [*2])
		else $error("functional reset pin not driven");
	AST_PH3_HOLD: assert property ((state_reg == RPBC_FUNC_THREE && !func_s && por_s) |=> state_reg == RPBC_FUNC_THREE)
		else $error("left phase three before release");
	AST_EXT_FUNC: assert property ((func_ext_low && por_s) |=> state_reg == (short_sel ? RPBC_FUNC_THREE
		: RPBC_FUNC_ONE))
		else $error("external functional reset wrong re-entry");
	AST_OPEN_DRAIN: assert property ((power_on_reset_pin_n_oe || functional_reset_pin_n_oe) |->
		!power_on_reset_pin_n_out && !functional_reset_pin_n_out)
		else $error("reset pin driven high");
	AST_BOOT_SERIAL: assert property (($rose(in_run) && capt_reg.fab && !capt_reg.sel_high) |->
		boot_mode == (capt_reg.sel_low ? RPBC_BOOT_CAN : RPBC_BOOT_UART))
		else $error("alternate boot decode wrong");
	AST_SECTOR: assert property (($rose(in_run) && !capt_reg.fab && $past(flash_sig_valid[0])) |->
		boot_sector == '0 && boot_mode == RPBC_BOOT_FLASH)
		else $error("lowest valid sector not chosen");
	AST_STATIC: assert property (($rose(in_run) && !capt_reg.fab && $past(flash_sig_valid) == '0) |->
		static_mode && !core_reset_n)
		else $error("static mode missing without signature");
	AST_PADS_HIZ: assert property (!in_run |-> !gpio_drive_allow && !test_data_out_oe && !crystal_output_drive_en)
		else $error("pad driven during reset");
	AST_CRYSTAL_OUTPUT_PIN: assert property (ext_clk_sel |-> !crystal_output_drive_en)
		else $error("crystal drive with external clock");
	AST_DEBUG: assert property (!debug_port_enable_pin |-> debug_port_reset && !debug_force)
		else $error("debug port not held in reset");

	CV_RUN: cover property ($rose(in_run));
	CV_POR_AGAIN: cover property (in_run ##1 state_reg == RPBC_PHASE_A);
	CV_SHORT: cover property (func_ext_low && short_sel);
	CV_STATIC: cover property ($rose(static_mode));

endmodule // rpbc_top

// ==== rpbc_board_model.sv ====
// board model: pull-ups on both reset pins, supervisor hold and strap drivers
`timescale 1ns/10ps
module rpbc_board_model
	import rpbc_pkg::*;
(
	input  wire logic            clock,
	input  wire logic            por_oe,
	input  wire logic            por_out,
	input  wire logic            func_oe,
	input  wire logic            func_out,
	input  wire logic            por_hold,
	input  wire logic            func_hold,
	input  wire rpbc_boot_pins_t strap_req,
	output logic                 por_pin,
	output logic                 func_pin,
	output rpbc_boot_pins_t      straps
);
	//////////////////////////////////////////////////////////////////////////
	// open drain wires: any party pulling low wins, otherwise the pull-up
	assign por_pin  = ((por_oe && !por_out) || por_hold) ? 1'b0 : 1'b1;
	assign func_pin = ((func_oe && !func_out) || func_hold) ? 1'b0 : 1'b1;

	// straps only move while power-on reset is held, so they stand from
	// before the sequence until well past the hold after functional release
	initial straps = '0;
	always @(posedge clock) begin
		if (!por_pin) begin
			straps <= strap_req;
		end
	end
endmodule // rpbc_board_model

// ==== tb.sv ====
// self-checking bench for the reset pin sequencer and boot capture
`timescale 1ns/10ps
module tb;
	import rpbc_pkg::*;
	logic            clock = 1'b0;
	logic            rst_b = 1'b0;
	logic [11:0]     s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]     s_axi_wdata = '0, s_axi_rdata, d;
	logic [3:0]      s_axi_wstrb = 4'hF, flash_sig_valid = 4'h4;
	logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic            s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]      s_axi_bresp, s_axi_rresp, boot_mode, boot_sector, r;
	logic            power_on_reset_pin_n_in, power_on_reset_pin_n_out, power_on_reset_pin_n_oe;
	logic            functional_reset_pin_n_in, functional_reset_pin_n_out, functional_reset_pin_n_oe;
	logic            reset_pin_pull_down_en, boot_pin_pull_down_en, test_in_pull_up_en, static_mode;
	logic            core_reset_n, gpio_drive_allow, test_data_out_oe, crystal_output_drive_en;
	logic            debug_port_reset, debug_force, debug_port_enable_pin = 1'b0, debug_event_input_n = 1'b1;
	logic            por_hold = 1'b1, func_hold = 1'b0;
	rpbc_boot_pins_t strap_req = '0, straps;
	int              errors = 0, checked = 0, seed, m, i, f, s, g;
	int              q[$];

	always #4 clock = ~clock;

	//////////////////////////////////////////////////////////////////////////
	rpbc_top #(.SECTORS(4), .SECT_W(2)) uut (
		.clock, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.power_on_reset_pin_n_in, .power_on_reset_pin_n_out, .power_on_reset_pin_n_oe,
		.functional_reset_pin_n_in, .functional_reset_pin_n_out, .functional_reset_pin_n_oe,
		.reset_pin_pull_down_en, .force_alternate_boot_pin(straps.fab),
		.boot_selector_bit_high(straps.sel_high), .boot_selector_bit_low(straps.sel_low),
		.boot_pin_pull_down_en, .flash_sig_valid, .boot_mode, .boot_sector, .static_mode, .core_reset_n,
		.gpio_drive_allow, .test_data_out_oe, .test_in_pull_up_en, .crystal_output_drive_en,
		.debug_port_enable_pin, .debug_event_input_n, .debug_port_reset, .debug_force);

	rpbc_board_model board (.clock, .por_oe(power_on_reset_pin_n_oe), .por_out(power_on_reset_pin_n_out),
		.func_oe(functional_reset_pin_n_oe), .func_out(functional_reset_pin_n_out), .por_hold, .func_hold,
		.strap_req, .por_pin(power_on_reset_pin_n_in), .func_pin(functional_reset_pin_n_in), .straps);

	//////////////////////////////////////////////////////////////////////////
	// reporting
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tally_and_finish;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task give_up;
		errors++;
		$display("FAIL t=%0t wait ran out", $time);
		tally_and_finish;
	endtask

	task cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// bus master: valid and payload held until taken, ready held until answer
	task axi_write(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= v;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clock);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		if (n == 100)
			give_up;
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task axi_read(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clock);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		if (n == 100)
			give_up;
		v = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// the whole sequence is some 660 cycles, so 1500 leaves margin
	task wait_run;
		int n;
		for (n = 0; n < 1500; n++) begin
			@(posedge clock);
			if (gpio_drive_allow === 1'b1)
				break;
		end
		if (n == 1500)
			give_up;
	endtask

	//////////////////////////////////////////////////////////////////////////
	// reference model of boot selection
	function automatic int exp_mode(int fb, int sl, int sg);
		if (fb == 0)
			return (sg == 0) ? 3 : 0;
		return (sl == 0) ? 1 : (sl == 1) ? 2 : 3;
	endfunction

	function automatic int low_sect(int sg);
		for (int k = 0; k < 4; k++) begin
			if (sg[k])
				return k;
		end
		return 0;
	endfunction

	//////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'hCC82F584;
		cyc(20);
		rst_b <= 1'b1;
		cyc(3);
		check(power_on_reset_pin_n_oe, 1);
		check(functional_reset_pin_n_oe, 1);
		check({power_on_reset_pin_n_out, functional_reset_pin_n_out}, 0);
		check({reset_pin_pull_down_en, boot_pin_pull_down_en, test_in_pull_up_en}, 7);
		// three driven edges already seen; count the rest of the power-on drive
		for (i = 3; i < 100; i++) begin
			@(posedge clock);
			if (power_on_reset_pin_n_oe !== 1'b1)
				break;
		end
		check(i, RPBC_POR_DRIVE_CYC);
		axi_read(RPBC_OFF_FESS, d, r);
		check(d, {30'h0, RPBC_FESS_RST});
		axi_write(12'h0FC, 32'hFFFFFFFF, r);
		check(r, RPBC_RESP_SLVERR);
		axi_read(12'h0FC, d, r);
		check(r, RPBC_RESP_SLVERR);
		check(d, 32'h0);
		cyc(40);
		axi_read(RPBC_OFF_STATUS, d, r);
		check(d[5:0], 1);
		$display("test power-on hold done");
		// functional pin held by the board keeps phase three
		@(posedge clock);
		func_hold <= 1'b1;
		por_hold <= 1'b0;
		cyc(80);
		axi_read(RPBC_OFF_STATUS, d, r);
		check(d[5:0], 8);
		check({gpio_drive_allow, core_reset_n}, 0);
		@(posedge clock);
		func_hold <= 1'b0;
		wait_run;
		check({boot_mode, boot_sector, core_reset_n}, 5'h05);
		$display("test sequence done");
		// every boot mode, straps taken while power-on reset is held
		for (i = 0; i < 8; i++) begin
			f = i / 4;
			s = i % 4;
			g = (i == 1) ? 0 : ($random(seed) & 15);
			@(posedge clock);
			strap_req <= {f[0], s[1:0]};
			flash_sig_valid <= g[3:0];
			por_hold <= 1'b1;
			cyc(6);
			axi_read(RPBC_OFF_STATUS, d, r);
			check(d[5:0], 1);
			@(posedge clock);
			por_hold <= 1'b0;
			wait_run;
			q.push_back(exp_mode(f, s, g));
			m = q.pop_front();
			check(boot_mode, m);
			check({static_mode, core_reset_n}, (m == 3) ? 2 : 1);
			if (m == 0)
				check(boot_sector, low_sect(g));
			axi_read(RPBC_OFF_CAPT, d, r);
			check(d[2:0], {f[0], s[1:0]});
		end
		$display("test boot modes done");
		// external functional reset re-enters phase one or three
		for (i = 0; i < 2; i++) begin
			axi_write(RPBC_OFF_FESS, i, r);
			@(posedge clock);
			func_hold <= 1'b1;
			cyc(6);
			check(functional_reset_pin_n_oe, (i == 0));
			cyc(30);
			axi_read(RPBC_OFF_STATUS, d, r);
			check(d[5:0], 8);
			@(posedge clock);
			func_hold <= 1'b0;
			wait_run;
		end
		$display("test external reset done");
		axi_write(RPBC_OFF_FESS, 2, r);
		check(r, RPBC_RESP_OKAY);
		axi_read(RPBC_OFF_FESS, d, r);
		check(d, 32'h2);
		check(r, RPBC_RESP_OKAY);
		cyc(2);
		check(crystal_output_drive_en, 0);
		axi_write(RPBC_OFF_FESS, 0, r);
		cyc(2);
		check(crystal_output_drive_en, 1);
		$display("test crystal done");
		for (i = 0; i < 4; i++) begin
			@(posedge clock);
			debug_port_enable_pin <= i[1];
			debug_event_input_n <= i[0];
			cyc(2);
			check(debug_port_reset, !i[1]);
			check(debug_force, i[1] && !i[0]);
			check(test_data_out_oe, i[1]);
		end
		$display("test debug done");
		tally_and_finish;
	end
endmodule // tb
